// ==== scale_pkg.sv ====
package scale_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and table sizes
  localparam int DISP_W  = 18;
  localparam int SIG_W   = 16;
  localparam int FRAC_W  = 16;
  localparam int NUM_W   = DISP_W + FRAC_W;
  localparam int SLOPE_W = NUM_W + 1;
  localparam int MAX_PTS = 10;
  localparam int IDX_W   = 4;
  localparam int HOLD_W  = 25;
  localparam int DCNT_W  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Menu, choice limits and reset values
  localparam logic [IDX_W-1:0]  MAX_SEGS       = 4'h9;
  localparam logic [IDX_W-1:0]  SEG_RST        = 4'h1;
  localparam logic [3:0]        MENU_LAST      = 4'h9;
  localparam logic [3:0]        MENU_EXIT      = 4'h0;
  localparam logic [3:0]        MENU_BY_SIGNAL = 4'h1;
  localparam logic [3:0]        MENU_BY_KEY    = 4'h2;
  localparam logic [2:0]        DP_LAST        = 3'h4;
  localparam logic [2:0]        ROUND_LAST     = 3'h6;
  localparam logic [2:0]        DP_RST         = 3'h0;
  localparam logic [2:0]        ROUND_RST      = 3'h0;
  localparam logic signed [DISP_W-1:0] DISP_MAX    = 18'sh1_869f;
  localparam logic signed [DISP_W-1:0] DISP_LO_RST = 18'sh0_0000;
  localparam logic signed [DISP_W-1:0] DISP_HI_RST = 18'sh0_2710;
  localparam logic [SIG_W-1:0]  SIG_LO_RST     = 16'h0000;
  localparam logic [SIG_W-1:0]  SIG_HI_RST     = 16'hffff;
  localparam logic [DCNT_W-1:0] DIV_STEPS      = 6'h22;

  ////////////////////////////////////////////////////////////////////////////
  // Key auto-repeat timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int CYCLES_PER_MS   = CLK_HZ / 1000;
  localparam int REPEAT_SLOW_MS  = 500;
  localparam int REPEAT_MID_MS   = 250;
  localparam int REPEAT_FAST_MS  = 100;
  localparam int REPEAT_SLOW_CYC = REPEAT_SLOW_MS * CYCLES_PER_MS;
  localparam int REPEAT_MID_CYC  = REPEAT_MID_MS * CYCLES_PER_MS;
  localparam int REPEAT_FAST_CYC = REPEAT_FAST_MS * CYCLES_PER_MS;
  localparam logic [3:0] REPEAT_SLOW_COUNT = 4'h4;
  localparam logic [3:0] REPEAT_MID_COUNT  = 4'hc;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    S_RUN       = 4'b0000,
    S_MENU      = 4'b0001,
    S_DP        = 4'b0010,
    S_ROUND     = 4'b0011,
    S_ASK_SCALE = 4'b0100,
    S_DSP       = 4'b0101,
    S_SIG       = 4'b0110,
    S_CALC      = 4'b0111,
    S_SEGS      = 4'b1000,
    S_ASK_LIN   = 4'b1001
  } step_t;

  typedef struct packed {
    logic prog;
    logic up;
    logic down;
  } keys_t;

  typedef struct packed {
    logic [2:0]       dp_pos;
    logic [2:0]       round_sel;
    logic [IDX_W-1:0] segment_count;
  } setup_cfg_t;

  // Rounding increment for each choice index
  function automatic logic [7:0] round_inc(input logic [2:0] sel);
    case (sel)
      3'h1:    round_inc = 8'h02;
      3'h2:    round_inc = 8'h05;
      3'h3:    round_inc = 8'h0a;
      3'h4:    round_inc = 8'h14;
      3'h5:    round_inc = 8'h32;
      3'h6:    round_inc = 8'h64;
      default: round_inc = 8'h01;
    endcase
  endfunction

endpackage

// ==== meter_scaling_setup.sv ====
// Overview of operation
// - Round scaled reading to nearest chosen increment
// - Increments include 10, 20, 50, 100
// - After rounding, ask: exit or scale points
// - Compute slope and offset automatically after points
// - One descending pair inverts, both keep normal
// - Capture step shows live, stores on program
// - Up/down in capture leaves stored signal
// - Key-in method takes both values as entries
// - Linearizer option continues with more points
// - Points needed equal segment count plus one
// - Inactive segments replaced by last slope extension
// - Count one returns; larger asks to continue
// - Enter display then signal per extra point
// - Held key repeats faster to ten-per-second rate
// - Decimal point kept; program stores and advances
// - Menu modules 0-9, up/down select, program enters modules 1 and 2
// - Module zero exits and commits to storage
module meter_scaling_setup #(
  parameter int REPEAT_SLOW_CYCLES = scale_pkg::REPEAT_SLOW_CYC,
  parameter int REPEAT_MID_CYCLES  = scale_pkg::REPEAT_MID_CYC,
  parameter int REPEAT_FAST_CYCLES = scale_pkg::REPEAT_FAST_CYC
) (
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  input  wire scale_pkg::keys_t                    keys,
  input  wire logic [scale_pkg::SIG_W-1:0]         live_signal,
  input  wire logic                                linearizer_present,
  output logic                                     setup_active,
  output scale_pkg::step_t                         step,
  output logic signed [scale_pkg::DISP_W-1:0]      shown_value,
  output scale_pkg::setup_cfg_t                    cfg,
  output logic                                     scaling_method,
  output logic                                     reverse_acting,
  output logic                                     nv_commit,
  output logic signed [scale_pkg::DISP_W-1:0]      scaled_reading
);

  localparam int DW = scale_pkg::DISP_W;
  localparam int SW = scale_pkg::SIG_W;
  localparam int NW = scale_pkg::NUM_W;
  localparam int PW = scale_pkg::MAX_PTS;
  localparam int IW = scale_pkg::IDX_W;
  localparam int HW = scale_pkg::HOLD_W;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key edges and auto-repeat
  scale_pkg::keys_t keys_prev_q;
  logic [HW-1:0]    hold_cnt_q, hold_cnt_d;
  logic [3:0]       rep_cnt_q, rep_cnt_d;
  logic             tick;
  logic             prog_evt, up_evt, down_evt;
  logic [HW-1:0]    period;

  always_comb begin
    prog_evt   = keys.prog & ~keys_prev_q.prog;
    tick       = 1'b0;
    hold_cnt_d = '0;
    rep_cnt_d  = '0;
    // Period shortens as the key stays down
    if (rep_cnt_q < scale_pkg::REPEAT_SLOW_COUNT) begin
      period = HW'(REPEAT_SLOW_CYCLES);
    end else if (rep_cnt_q < scale_pkg::REPEAT_MID_COUNT) begin
      period = HW'(REPEAT_MID_CYCLES);
    end else begin
      period = HW'(REPEAT_FAST_CYCLES);
    end
    if (keys.up ^ keys.down) begin
      if ((keys.up & ~keys_prev_q.up) | (keys.down & ~keys_prev_q.down)) begin
        tick = 1'b1;
      end else if (hold_cnt_q + 1'b1 >= period) begin
        tick      = 1'b1;
        rep_cnt_d = (rep_cnt_q == 4'hf) ? rep_cnt_q : rep_cnt_q + 1'b1;
      end else begin
        hold_cnt_d = hold_cnt_q + 1'b1;
        rep_cnt_d  = rep_cnt_q;
      end
    end
    up_evt   = tick & keys.up;
    down_evt = tick & keys.down;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      keys_prev_q <= '0;
      hold_cnt_q  <= '0;
      rep_cnt_q   <= '0;
    end else begin
      keys_prev_q <= keys;
      hold_cnt_q  <= hold_cnt_d;
      rep_cnt_q   <= rep_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup sequencer, point table and slope divider
  scale_pkg::step_t         step_q, step_d;
  scale_pkg::setup_cfg_t    cfg_q, cfg_d;
  logic                     setup_q, setup_d;
  logic                     method_q, method_d;
  logic                     commit_q, commit_d;
  logic [3:0]               menu_q, menu_d;
  logic [IW-1:0]            idx_q, idx_d;
  logic signed [DW-1:0]     edit_q, edit_d;
  logic signed [DW-1:0]     shown_q, shown_d;
  logic signed [DW-1:0]     disp_q [PW], disp_d [PW];
  logic [SW-1:0]            sig_q [PW], sig_d [PW];
  logic signed [NW:0]       slope_q [PW-1], slope_d [PW-1];
  logic [IW-1:0]            cseg_q, cseg_d;
  logic [5:0]               dcnt_q, dcnt_d;
  logic [SW:0]              rem_q, rem_d;
  logic [NW-1:0]            quo_q, quo_d;
  logic [SW-1:0]            den_q, den_d;
  logic                     neg_q, neg_d;
  logic signed [DW-1:0]     raw_q, raw_d;
  logic signed [DW-1:0]     rnd_q, rnd_d;
  logic signed [DW:0]       dd;
  logic signed [SW:0]       ds;
  logic [SW:0]              r;
  logic [NW-1:0]            q;
  logic signed [DW-1:0]     live_s;

  always_comb begin
    step_d   = step_q;
    cfg_d    = cfg_q;
    setup_d  = setup_q;
    method_d = method_q;
    commit_d = 1'b0;
    menu_d   = menu_q;
    idx_d    = idx_q;
    edit_d   = edit_q;
    disp_d   = disp_q;
    sig_d    = sig_q;
    slope_d  = slope_q;
    cseg_d   = cseg_q;
    dcnt_d   = dcnt_q;
    rem_d    = rem_q;
    quo_d    = quo_q;
    den_d    = den_q;
    neg_d    = neg_q;
    live_s   = DW'($signed({2'b00, live_signal}));
    dd       = '0;
    ds       = '0;
    r        = '0;
    q        = '0;
    case (step_q)
      scale_pkg::S_RUN: begin
        if (prog_evt) begin
          step_d  = scale_pkg::S_MENU;
          menu_d  = scale_pkg::MENU_EXIT;
          setup_d = 1'b1;
        end
      end
      scale_pkg::S_MENU: begin
        // Module choice wraps 0..9
        if (up_evt) begin
          menu_d = (menu_q == scale_pkg::MENU_LAST) ? 4'h0 : menu_q + 1'b1;
        end else if (down_evt) begin
          menu_d = (menu_q == 4'h0) ? scale_pkg::MENU_LAST : menu_q - 1'b1;
        end else if (prog_evt) begin
          case (menu_q)
            scale_pkg::MENU_EXIT: begin
              commit_d = 1'b1;
              setup_d  = 1'b0;
              step_d   = scale_pkg::S_RUN;
            end
            scale_pkg::MENU_BY_SIGNAL, scale_pkg::MENU_BY_KEY: begin
              method_d = (menu_q == scale_pkg::MENU_BY_KEY);
              menu_d   = scale_pkg::MENU_EXIT;
              step_d   = scale_pkg::S_DP;
              edit_d   = DW'(cfg_q.dp_pos);
            end
            default: begin
              step_d = scale_pkg::S_MENU;
            end
          endcase
        end
      end
      scale_pkg::S_DP: begin
        if (up_evt && edit_q < DW'(scale_pkg::DP_LAST)) edit_d = edit_q + 1'b1;
        if (down_evt && edit_q != 0) edit_d = edit_q - 1'b1;
        if (prog_evt) begin
          cfg_d.dp_pos = edit_q[2:0];
          edit_d       = DW'(cfg_q.round_sel);
          step_d       = scale_pkg::S_ROUND;
        end
      end
      scale_pkg::S_ROUND: begin
        if (up_evt && edit_q < DW'(scale_pkg::ROUND_LAST)) edit_d = edit_q + 1'b1;
        if (down_evt && edit_q != 0) edit_d = edit_q - 1'b1;
        if (prog_evt) begin
          cfg_d.round_sel = edit_q[2:0];
          edit_d          = '0;
          step_d          = scale_pkg::S_ASK_SCALE;
        end
      end
      scale_pkg::S_ASK_SCALE, scale_pkg::S_ASK_LIN: begin
        // Yes/no choice held in bit 0
        if (up_evt | down_evt) edit_d = {{(DW-1){1'b0}}, ~edit_q[0]};
        if (prog_evt) begin
          if (!edit_q[0]) begin
            step_d = scale_pkg::S_MENU;
          end else begin
            idx_d  = (step_q == scale_pkg::S_ASK_LIN) ? 4'h2 : 4'h0;
            edit_d = disp_q[(step_q == scale_pkg::S_ASK_LIN) ? 2 : 0];
            step_d = scale_pkg::S_DSP;
          end
        end
      end
      scale_pkg::S_DSP: begin
        if (up_evt && edit_q < scale_pkg::DISP_MAX) edit_d = edit_q + 1'b1;
        if (down_evt && edit_q > -scale_pkg::DISP_MAX) edit_d = edit_q - 1'b1;
        if (prog_evt) begin
          disp_d[idx_q] = edit_q;
          edit_d        = DW'($signed({2'b00, sig_q[idx_q]}));
          step_d        = scale_pkg::S_SIG;
        end
      end
      scale_pkg::S_SIG: begin
        // Up/down only move the keyed entry; capture ignores them
        if (method_q) begin
          if (up_evt && edit_q < DW'($signed({2'b00, scale_pkg::SIG_HI_RST}))) edit_d = edit_q + 1'b1;
          if (down_evt && edit_q != 0) edit_d = edit_q - 1'b1;
        end
        if (prog_evt) begin
          sig_d[idx_q] = method_q ? edit_q[SW-1:0] : live_signal;
          if (idx_q == 4'h1 || idx_q >= cfg_q.segment_count) begin
            step_d = scale_pkg::S_CALC;
            cseg_d = '0;
            dcnt_d = '0;
          end else begin
            idx_d  = idx_q + 1'b1;
            edit_d = disp_q[idx_q + 1'b1];
            step_d = scale_pkg::S_DSP;
          end
        end
      end
      scale_pkg::S_CALC: begin
        dd = DW'(disp_q[cseg_q + 1'b1]) - DW'(disp_q[cseg_q]);
        ds = $signed({1'b0, sig_q[cseg_q + 1'b1]}) - $signed({1'b0, sig_q[cseg_q]});
        if (dcnt_q == 6'h0) begin
          // Load magnitudes; sign follows which pair descends
          quo_d  = NW'(dd < 0 ? -dd : dd) << scale_pkg::FRAC_W;
          den_d  = SW'(ds < 0 ? -ds : ds);
          neg_d  = (dd < 0) ^ (ds < 0);
          rem_d  = '0;
          dcnt_d = 6'h1;
        end else begin
          r = {rem_q[SW-1:0], quo_q[NW-1]};
          q = {quo_q[NW-2:0], 1'b0};
          if (r >= {1'b0, den_q}) begin
            r    = r - {1'b0, den_q};
            q[0] = 1'b1;
          end
          rem_d = r;
          quo_d = q;
          if (dcnt_q == scale_pkg::DIV_STEPS) begin
            if (den_q == '0) slope_d[cseg_q] = '0;
            else slope_d[cseg_q] = neg_q ? -$signed({1'b0, q}) : $signed({1'b0, q});
            dcnt_d = 6'h0;
            if (cseg_q == scale_pkg::MAX_SEGS - 1'b1) begin
              if (!setup_q) begin
                step_d = scale_pkg::S_RUN;
              end else if (idx_q == 4'h1 && linearizer_present) begin
                step_d = scale_pkg::S_SEGS;
                edit_d = DW'(cfg_q.segment_count);
              end else begin
                step_d = scale_pkg::S_MENU;
              end
            end else begin
              cseg_d = cseg_q + 1'b1;
            end
          end else begin
            dcnt_d = dcnt_q + 1'b1;
          end
        end
      end
      scale_pkg::S_SEGS: begin
        if (up_evt && edit_q < DW'(scale_pkg::MAX_SEGS)) edit_d = edit_q + 1'b1;
        if (down_evt && edit_q > 1) edit_d = edit_q - 1'b1;
        if (prog_evt) begin
          cfg_d.segment_count = edit_q[IW-1:0];
          step_d = (edit_q == 1) ? scale_pkg::S_MENU : scale_pkg::S_ASK_LIN;
          edit_d = '0;
        end
      end
      default: begin
        step_d = scale_pkg::S_RUN;
      end
    endcase
    // Shown value: live input while capturing, module number in menu, else entry or reading
    case (step_q)
      scale_pkg::S_RUN:  shown_d = rnd_q;
      scale_pkg::S_MENU: shown_d = DW'(menu_q);
      scale_pkg::S_SIG:  shown_d = method_q ? edit_q : live_s;
      default:           shown_d = edit_q;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q   <= scale_pkg::S_CALC;
      cfg_q    <= '{dp_pos: scale_pkg::DP_RST, round_sel: scale_pkg::ROUND_RST,
                    segment_count: scale_pkg::SEG_RST};
      setup_q  <= 1'b0;
      method_q <= 1'b0;
      commit_q <= 1'b0;
      menu_q   <= scale_pkg::MENU_EXIT;
      idx_q    <= '0;
      edit_q   <= '0;
      shown_q  <= '0;
      for (int i = 0; i < PW; i++) begin
        disp_q[i] <= (i == 0) ? scale_pkg::DISP_LO_RST : scale_pkg::DISP_HI_RST;
        sig_q[i]  <= (i == 0) ? scale_pkg::SIG_LO_RST : scale_pkg::SIG_HI_RST;
      end
      for (int i = 0; i < PW - 1; i++) slope_q[i] <= '0;
      cseg_q <= '0;
      dcnt_q <= '0;
      rem_q  <= '0;
      quo_q  <= '0;
      den_q  <= '0;
      neg_q  <= 1'b0;
    end else begin
      step_q   <= step_d;
      cfg_q    <= cfg_d;
      setup_q  <= setup_d;
      method_q <= method_d;
      commit_q <= commit_d;
      menu_q   <= menu_d;
      idx_q    <= idx_d;
      edit_q   <= edit_d;
      shown_q  <= shown_d;
      disp_q   <= disp_d;
      sig_q    <= sig_d;
      slope_q  <= slope_d;
      cseg_q   <= cseg_d;
      dcnt_q   <= dcnt_d;
      rem_q    <= rem_d;
      quo_q    <= quo_d;
      den_q    <= den_d;
      neg_q    <= neg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reading path: segment select, interpolate, round
  logic [PW-2:0] beyond;
  logic          ascend;

  assign ascend    = sig_q[1] >= sig_q[0];
  assign beyond[0] = 1'b0;

  // Per-segment bracket test against the live input
  for (genvar g = 1; g < PW - 1; g++) begin : g_seg
    assign beyond[g] = (IW'(g) < cfg_q.segment_count) &&
                       (ascend ? live_signal >= sig_q[g] : live_signal <= sig_q[g]);
  end

  logic [IW-1:0]               sel;
  logic signed [SW:0]          dx;
  logic signed [NW+SW+1:0]     prod;
  logic signed [NW+SW+1:0]     sum;
  logic [DW-1:0]               mag;
  logic [DW+7:0]               rmag;
  logic [7:0]                  inc;

  always_comb begin
    sel = '0;
    for (int i = 1; i < PW - 1; i++) begin
      if (beyond[i]) sel = IW'(i);
    end
    dx   = $signed({1'b0, live_signal}) - $signed({1'b0, sig_q[sel]});
    prod = slope_q[sel] * dx;
    sum  = (prod >>> scale_pkg::FRAC_W) + disp_q[sel];
    if (sum > scale_pkg::DISP_MAX) raw_d = scale_pkg::DISP_MAX;
    else if (sum < -scale_pkg::DISP_MAX) raw_d = -scale_pkg::DISP_MAX;
    else raw_d = DW'(sum);
    // Round magnitude half-up to the chosen increment
    inc  = scale_pkg::round_inc(cfg_q.round_sel);
    mag  = raw_q[DW-1] ? DW'(-raw_q) : DW'(raw_q);
    rmag = (({8'h00, mag} + (inc >> 1)) / inc) * inc;
    rnd_d = raw_q[DW-1] ? -$signed(DW'(rmag)) : $signed(DW'(rmag));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_q <= '0;
      rnd_q <= '0;
    end else begin
      raw_q <= raw_d;
      rnd_q <= rnd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign setup_active   = setup_q;
  assign step           = step_q;
  assign shown_value    = shown_q;
  assign cfg            = cfg_q;
  assign scaling_method = method_q;
  assign reverse_acting = slope_q[0][NW];
  assign nv_commit      = commit_q;
  assign scaled_reading = rnd_q;

endmodule

// ==== meter_scaling_setup_properties.sv ====
module meter_scaling_setup_properties (
  input wire logic                                core_clk,
  input wire logic                                reset_n,
  input wire scale_pkg::keys_t                    keys,
  input wire logic [scale_pkg::SIG_W-1:0]         live_signal,
  input wire logic                                linearizer_present,
  input wire logic                                setup_active,
  input wire scale_pkg::step_t                    step,
  input wire logic signed [scale_pkg::DISP_W-1:0] shown_value,
  input wire scale_pkg::setup_cfg_t               cfg,
  input wire logic                                scaling_method,
  input wire logic                                reverse_acting,
  input wire logic                                nv_commit,
  input wire logic signed [scale_pkg::DISP_W-1:0] scaled_reading
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Menu entry and exit
  chk_menu_enter: assert property ($rose(keys.prog) && step == scale_pkg::S_RUN |=> step == scale_pkg::S_MENU && setup_active)
    else $error("program key in run did not open the menu");
  chk_commit_pulse: assert property ($rose(nv_commit) |-> step == scale_pkg::S_RUN && !setup_active ##1 !nv_commit)
    else $error("commit pulse wrong shape or state");
  chk_commit_cause: assert property (nv_commit |-> $past(step) == scale_pkg::S_MENU)
    else $error("commit pulse without menu exit");

  ////////////////////////////////////////////////////////////////////////////
  // Step sequencing on the program key; up/down keep the capture step
  chk_dp_advance: assert property ($rose(keys.prog) && step == scale_pkg::S_DP |=> step == scale_pkg::S_ROUND)
    else $error("decimal point step did not advance");
  chk_round_ask: assert property ($rose(keys.prog) && step == scale_pkg::S_ROUND |=> step == scale_pkg::S_ASK_SCALE)
    else $error("rounding step did not offer the choice");
  chk_ask_branch: assert property ($rose(keys.prog) && step == scale_pkg::S_ASK_SCALE |=> step inside {scale_pkg::S_MENU, scale_pkg::S_DSP})
    else $error("scale choice went elsewhere");
  chk_dsp_sig: assert property ($rose(keys.prog) && step == scale_pkg::S_DSP |=> step == scale_pkg::S_SIG)
    else $error("display value not followed by signal value");
  chk_seg_one: assert property ($rose(keys.prog) && step == scale_pkg::S_SEGS |=> cfg.segment_count != 4'h1 || step == scale_pkg::S_MENU)
    else $error("single segment did not return to menu");
  chk_seg_more: assert property ($rose(keys.prog) && step == scale_pkg::S_SEGS |=> cfg.segment_count == 4'h1 || step == scale_pkg::S_ASK_LIN)
    else $error("several segments did not offer the choice");
  chk_sig_updown: assert property (step == scale_pkg::S_SIG && ($rose(keys.up) || $rose(keys.down)) |=> step == scale_pkg::S_SIG)
    else $error("up or down left the capture step");

  ////////////////////////////////////////////////////////////////////////////
  // Calculation length, limits and rounding
  chk_calc_bound: assert property (step == scale_pkg::S_CALC |-> ##[0:330] step != scale_pkg::S_CALC)
    else $error("slope calculation did not finish");
  chk_cfg_limits: assert property (cfg.dp_pos <= 3'h4 && cfg.segment_count inside {[4'h1:4'h9]})
    else $error("setup value outside its range");
  chk_round_ten: assert property (cfg.round_sel == 3'h3 && $past(cfg.round_sel, 2) == 3'h3 |-> scaled_reading % 10 == 0)
    else $error("reading not a multiple of ten");
endmodule

bind meter_scaling_setup meter_scaling_setup_properties meter_scaling_setup_properties_inst (
  .core_clk(core_clk), .reset_n(reset_n), .keys(keys), .live_signal(live_signal),
  .linearizer_present(linearizer_present), .setup_active(setup_active), .step(step),
  .shown_value(shown_value), .cfg(cfg), .scaling_method(scaling_method), .reverse_acting(reverse_acting),
  .nv_commit(nv_commit), .scaled_reading(scaled_reading)
);

// ==== key_operator.sv ====
module key_operator (
  input  wire logic        core_clk,
  output scale_pkg::keys_t keys
);
  timeunit 1ns;
  timeprecision 1ps;

  // Keys idle until the operator acts
  initial keys = '0;

  // Press a key for hold cycles, then let go and pause, count times over
  task automatic tap(input logic [2:0] k, input int hold, input int times);
    repeat (times) begin
      @(negedge core_clk);
      keys = scale_pkg::keys_t'(k);
      repeat (hold) @(negedge core_clk);
      keys = '0;
      repeat (3) @(negedge core_clk);
    end
  endtask
endmodule

// ==== meter_scaling_setup_tb.sv ====
module meter_scaling_setup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] KP = 3'b100;
  localparam logic [2:0] KU = 3'b010;
  localparam logic [2:0] KD = 3'b001;
  logic                                core_clk;
  logic                                reset_n;
  scale_pkg::keys_t                    keys;
  logic [scale_pkg::SIG_W-1:0]         live_signal;
  logic                                linearizer_present;
  logic                                setup_active;
  scale_pkg::step_t                    step;
  logic signed [scale_pkg::DISP_W-1:0] shown_value;
  scale_pkg::setup_cfg_t               cfg;
  logic                                scaling_method;
  logic                                reverse_acting;
  logic                                nv_commit;
  logic signed [scale_pkg::DISP_W-1:0] scaled_reading;
  int                                  err_count;
  int                                  cmp_count;
  int                                  commits;

  meter_scaling_setup #(.REPEAT_SLOW_CYCLES(8), .REPEAT_MID_CYCLES(6), .REPEAT_FAST_CYCLES(4)) meter_scaling_setup_inst (
    .core_clk(core_clk), .reset_n(reset_n), .keys(keys), .live_signal(live_signal),
    .linearizer_present(linearizer_present), .setup_active(setup_active), .step(step),
    .shown_value(shown_value), .cfg(cfg), .scaling_method(scaling_method), .reverse_acting(reverse_acting),
    .nv_commit(nv_commit), .scaled_reading(scaled_reading)
  );
  key_operator key_operator_inst (.core_clk(core_clk), .keys(keys));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and commit pulse counter
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (nv_commit === 1'b1) commits <= commits + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic press(input logic [2:0] k, input int times);
    key_operator_inst.tap(k, 1, times);
  endtask
  task automatic wait_step(input scale_pkg::step_t s);
    int n;
    n = 0;
    while (step !== s && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    check(step, s);
  endtask
  task automatic reading(input logic [15:0] sig, input logic [31:0] exp);
    live_signal = sig;
    repeat (4) @(negedge core_clk);
    check(scaled_reading, exp);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    wait_step(scale_pkg::S_RUN);
    check(setup_active, 0);
    check(cfg.segment_count, 1);
  endtask
  task automatic t_menu();
    int c;
    press(KP, 1);
    check(step, scale_pkg::S_MENU);
    press(KD, 1);
    check(shown_value, 9);
    press(KU, 1);
    check(shown_value, 0);
    c = commits;
    press(KP, 1);
    check(step, scale_pkg::S_RUN);
    check(commits, c + 1);
  endtask
  task automatic t_ask_no();
    press(KP, 1);
    press(KU, 1);
    press(KP, 4);
    check(step, scale_pkg::S_MENU);
    press(KP, 1);
  endtask
  task automatic t_keyin();
    press(KP, 1);
    press(KU, 2);
    press(KP, 1);
    check(step, scale_pkg::S_DP);
    key_operator_inst.tap(KU, 13, 1);
    check(shown_value, 2);
    press(KP, 1);
    press(KU, 3);
    press(KP, 1);
    check(cfg.round_sel, 3);
    press(KU, 1);
    press(KP, 1);
    check(step, scale_pkg::S_DSP);
    press(KP, 4);
    wait_step(scale_pkg::S_SEGS);
    check(scaling_method, 1);
    check(cfg.dp_pos, 2);
    press(KP, 1);
    check(step, scale_pkg::S_MENU);
    press(KP, 1);
    reading(16'h0c00, 470);
    reading(16'hffff, 10000);
    check(reverse_acting, 0);
  endtask
  task automatic t_capture();
    press(KP, 1);
    press(KU, 1);
    press(KP, 3);
    press(KU, 1);
    press(KP, 2);
    live_signal = 16'hffff;
    repeat (3) @(negedge core_clk);
    check(shown_value, 65535);
    press(KD, 1);
    check(step, scale_pkg::S_SIG);
    press(KP, 2);
    live_signal = 16'h0000;
    press(KP, 1);
    wait_step(scale_pkg::S_SEGS);
    press(KU, 1);
    press(KP, 1);
    check(step, scale_pkg::S_ASK_LIN);
    press(KP, 1);
    check(step, scale_pkg::S_MENU);
    check(scaling_method, 0);
    check(reverse_acting, 1);
    press(KP, 1);
    reading(16'h0c00, 9530);
    reading(16'h0000, 10000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    reset_n = 1'b0;
    live_signal = 16'h0000;
    linearizer_present = 1'b1;
    err_count = 0;
    cmp_count = 0;
    commits = 0;
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    t_reset();
    t_menu();
    t_ask_no();
    t_keyin();
    t_capture();
    give_verdict();
  end
  initial begin
    #200us;
    err_count++;
    give_verdict();
  end
endmodule
